// file: src/timer16_defs.svh
`ifndef TIMER16_DEFS_SVH
`define TIMER16_DEFS_SVH

// register byte offsets
`define OFF_CTRL   8'h00
`define OFF_COUNT  8'h04
`define OFF_CMPA   8'h08
`define OFF_CMPB   8'h0c
`define OFF_CAPTOP 8'h10
`define OFF_FLAGS  8'h14

// flag bit positions
`define FLG_OVF 0
`define FLG_MA  1
`define FLG_MB  2
`define FLG_CAP 3

// counter values
`define TOP_8BIT   16'h00ff
`define TOP_9BIT   16'h01ff
`define TOP_10BIT  16'h03ff
`define CNT_MAX    16'hffff
`define CNT_BOTTOM 16'h0000

// clock select codes and prescale masks
`define CS_DIV1    3'h1
`define CS_DIV8    3'h2
`define CS_DIV64   3'h3
`define CS_DIV256  3'h4
`define CS_DIV1024 3'h5
`define PRE_8      10'h007
`define PRE_64     10'h03f
`define PRE_256    10'h0ff
`define PRE_1024   10'h3ff

// compare output selector codes
`define COM_TOGGLE 2'h1
`define COM_2      2'h2
`define COM_3      2'h3

// reset values
`define CTRL_RST  13'h0000
`define CNT_RST   16'h0000
`define CMP_RST   16'h0000
`define CAP_RST   16'h0000
`define FLAGS_RST 4'h0
`define RDY_RST   1'b1

// bus responses
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

// file: src/timer16_pkg.sv
package timer16_pkg;

    typedef enum logic [3:0]
    {
        M_NORMAL   = 4'h0,
        M_PC8      = 4'h1,
        M_PC9      = 4'h2,
        M_PC10     = 4'h3,
        M_CTC_A    = 4'h4,
        M_FAST8    = 4'h5,
        M_FAST9    = 4'h6,
        M_FAST10   = 4'h7,
        M_PFC_CAP  = 4'h8,
        M_PFC_A    = 4'h9,
        M_PC_CAP   = 4'ha,
        M_PC_A     = 4'hb,
        M_CTC_CAP  = 4'hc,
        M_RSVD     = 4'hd,
        M_FAST_CAP = 4'he,
        M_FAST_A   = 4'hf
    } mode_e;

    typedef enum logic
    {
        DIR_UP   = 1'b0,
        DIR_DOWN = 1'b1
    } dir_e;

    typedef struct packed
    {
        logic [1:0] pin_dir;
        logic [2:0] clk_sel;
        logic [1:0] com_b;
        logic [1:0] com_a;
        mode_e      mode;
    } ctrl_s;

    typedef struct packed
    {
        logic        fast;
        logic        dual;
        logic        pfc;
        logic        top_cap;
        logic        top_a;
        logic [15:0] fixed;
    } mdec_s;

endpackage

// file: src/timer16_pwm.sv
`timescale 1ns/100ps
`include "timer16_defs.svh"
// Behaviour
// - overflow flag set as counter wraps max to zero
// - counter advances only on prescaled enable pulses
// - fast modes count up zero to top
// - fast top fixed, capture or compare a
// - fast output toggles between match and wrap
// - fast selector two inverted, three non-inverted
// - fast overflow and top flag at top
// - fixed top masks written compare upper bits
// - capture top unbuffered, overshoot wraps at max
// - fast compare a loads buffer at top
// - fast extremes give spike or constant level
// - fast mode f toggle gives half duty
// - phase correct modes count up then down
// - phase correct top source, held one tick
// - phase correct output by slope direction
// - phase correct selector two non-inverted
// - phase correct overflow at bottom, top flag
// - phase correct extremes give constant levels
// - phase correct mode b toggle half duty
// - pin shows waveform only when output
// - pwm compares double buffered, others direct
// - match flag set the clock after the matching tick, write one clears
module timer16_pwm
(
    input  logic        clk,
    input  logic        srst,
    input  logic [7:0]  s_axi_awaddr,
    input  logic        s_axi_awvalid,
    output logic        s_axi_awready,
    input  logic [31:0] s_axi_wdata,
    input  logic [3:0]  s_axi_wstrb,
    input  logic        s_axi_wvalid,
    output logic        s_axi_wready,
    output logic [1:0]  s_axi_bresp,
    output logic        s_axi_bvalid,
    input  logic        s_axi_bready,
    input  logic [7:0]  s_axi_araddr,
    input  logic        s_axi_arvalid,
    output logic        s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0]  s_axi_rresp,
    output logic        s_axi_rvalid,
    input  logic        s_axi_rready,
    output logic        waveform_output_a,
    output logic        waveform_output_a_oe,
    output logic        waveform_output_b,
    output logic        waveform_output_b_oe
);

    timer16_pkg::ctrl_s ctrl_r;
    timer16_pkg::ctrl_s ctrl_nxt;
    timer16_pkg::mdec_s md;
    timer16_pkg::dir_e  dir_r;
    timer16_pkg::dir_e  dir_nxt;
    logic [15:0]        cnt_r;
    logic [15:0]        cnt_nxt;
    logic [15:0]        cap_r;
    logic [15:0]        cap_nxt;
    logic [3:0]         flags_r;
    logic [3:0]         flags_nxt;
    logic [3:0]         flg_set;
    logic [3:0]         flg_clr;
    logic [9:0]         pre_r;
    logic [9:0]         pre_nxt;
    logic [15:0]        top;
    logic [15:0]        ctrl_w;
    logic               tick;
    logic               at_top;
    logic               at_max;
    logic               wrap;
    logic               bottom_dn;
    logic               up_eff;
    logic               upd;
    logic               tgl_mode;
    logic               awready_r;
    logic               awready_nxt;
    logic               wready_r;
    logic               wready_nxt;
    logic               bvalid_r;
    logic               bvalid_nxt;
    logic [1:0]         bresp_r;
    logic [1:0]         bresp_nxt;
    logic               arready_r;
    logic               arready_nxt;
    logic               rvalid_r;
    logic               rvalid_nxt;
    logic [1:0]         rresp_r;
    logic [1:0]         rresp_nxt;
    logic [31:0]        rdata_r;
    logic [31:0]        rdata_nxt;
    logic               aw_h_r;
    logic               aw_h_nxt;
    logic               w_h_r;
    logic               w_h_nxt;
    logic [7:0]         awaddr_r;
    logic [7:0]         awaddr_nxt;
    logic [31:0]        wdata_r;
    logic [31:0]        wdata_nxt;
    logic [3:0]         wstrb_r;
    logic [3:0]         wstrb_nxt;
    logic               wr_en;
    logic               wr_hit;
    logic [31:0]        rd_val;
    logic               rd_hit;

    function automatic logic [15:0] merge16
    (
        input logic [15:0] old,
        input logic [31:0] d,
        input logic [3:0]  s
    );
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // field order: fast, dual, pfc, top from capture, top from compare a
    always_comb
    begin
        case (ctrl_r.mode)
            timer16_pkg::M_PC8:      md = {5'h08, `TOP_8BIT};
            timer16_pkg::M_PC9:      md = {5'h08, `TOP_9BIT};
            timer16_pkg::M_PC10:     md = {5'h08, `TOP_10BIT};
            timer16_pkg::M_CTC_A:    md = {5'h01, `CNT_MAX};
            timer16_pkg::M_FAST8:    md = {5'h10, `TOP_8BIT};
            timer16_pkg::M_FAST9:    md = {5'h10, `TOP_9BIT};
            timer16_pkg::M_FAST10:   md = {5'h10, `TOP_10BIT};
            timer16_pkg::M_PFC_CAP:  md = {5'h0e, `CNT_MAX};
            timer16_pkg::M_PFC_A:    md = {5'h0d, `CNT_MAX};
            timer16_pkg::M_PC_CAP:   md = {5'h0a, `CNT_MAX};
            timer16_pkg::M_PC_A:     md = {5'h09, `CNT_MAX};
            timer16_pkg::M_CTC_CAP:  md = {5'h02, `CNT_MAX};
            timer16_pkg::M_FAST_CAP: md = {5'h12, `CNT_MAX};
            timer16_pkg::M_FAST_A:   md = {5'h11, `CNT_MAX};
            default:                 md = {5'h00, `CNT_MAX};
        endcase
    end

    // a shared free-running prescaler keeps the design on one clock
    always_comb
    begin
        case (ctrl_r.clk_sel)
            `CS_DIV1:    tick = 1'b1;
            `CS_DIV8:    tick = (pre_r & `PRE_8) == `PRE_8;
            `CS_DIV64:   tick = (pre_r & `PRE_64) == `PRE_64;
            `CS_DIV256:  tick = (pre_r & `PRE_256) == `PRE_256;
            `CS_DIV1024: tick = pre_r == `PRE_1024;
            default:     tick = 1'b0;
        endcase
    end

    assign top       = md.top_cap ? cap_r :
                       (md.top_a ? ch[0].ocr_r : md.fixed);
    assign at_top    = cnt_r == top;
    assign at_max    = cnt_r == `CNT_MAX;
    // a top written below the count is missed until max
    assign wrap      = at_top | at_max;
    assign bottom_dn = dir_r == timer16_pkg::DIR_DOWN
                       && cnt_r == `CNT_BOTTOM;
    assign up_eff    = cnt_r == `CNT_BOTTOM
                       || (dir_r == timer16_pkg::DIR_UP && !at_top);
    assign upd       = tick & (md.fast ? wrap :
                       (md.pfc ? bottom_dn :
                       (md.dual & dir_r == timer16_pkg::DIR_UP & wrap)));
    assign tgl_mode  = ctrl_r.mode == timer16_pkg::M_FAST_A
                       || ctrl_r.mode == timer16_pkg::M_PC_A
                       || ctrl_r.mode == timer16_pkg::M_PFC_A;
    assign ctrl_w    = merge16({3'h0, ctrl_r}, wdata_r, wstrb_r);
    assign wr_en     = aw_h_r & w_h_r;

    always_comb
    begin
        flg_set = 4'h0;
        if (tick)
        begin
            if (md.fast)
                flg_set[`FLG_OVF] = wrap;
            else if (md.dual)
                flg_set[`FLG_OVF] = bottom_dn;
            else
                flg_set[`FLG_OVF] = at_max;
            flg_set[`FLG_CAP] = md.top_cap & at_top;
        end
        flg_set[`FLG_MA] = ch[0].hit;
        flg_set[`FLG_MB] = ch[1].hit;
        flg_clr = 4'h0;
        if (wr_en && awaddr_r == `OFF_FLAGS && wstrb_r[0])
            flg_clr = wdata_r[3:0];
    end

    always_comb
    begin
        pre_nxt   = pre_r + 10'h001;
        ctrl_nxt  = ctrl_r;
        cnt_nxt   = cnt_r;
        dir_nxt   = dir_r;
        cap_nxt   = cap_r;
        // a flag event in the clearing cycle survives
        flags_nxt = (flags_r & ~flg_clr) | flg_set;
        if (tick)
        begin
            if (!md.dual)
                cnt_nxt = wrap ? `CNT_BOTTOM : cnt_r + 16'h0001;
            else if (dir_r == timer16_pkg::DIR_UP)
            begin
                if (wrap)
                begin
                    dir_nxt = timer16_pkg::DIR_DOWN;
                    cnt_nxt = cnt_r - 16'h0001;
                end
                else
                    cnt_nxt = cnt_r + 16'h0001;
            end
            else if (cnt_r == `CNT_BOTTOM)
            begin
                dir_nxt = timer16_pkg::DIR_UP;
                cnt_nxt = cnt_r + 16'h0001;
            end
            else
                cnt_nxt = cnt_r - 16'h0001;
        end
        if (wr_en)
        begin
            case (awaddr_r)
                `OFF_CTRL:   ctrl_nxt = timer16_pkg::ctrl_s'(ctrl_w[12:0]);
                `OFF_COUNT:  cnt_nxt = merge16(cnt_r, wdata_r, wstrb_r);
                `OFF_CAPTOP:
                    cap_nxt = merge16(cap_r, wdata_r, wstrb_r);
                default:     cnt_nxt = cnt_nxt;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pre_r   <= 10'h000;
            ctrl_r  <= `CTRL_RST;
            cnt_r   <= `CNT_RST;
            dir_r   <= timer16_pkg::DIR_UP;
            cap_r   <= `CAP_RST;
            flags_r <= `FLAGS_RST;
        end
        else
        begin
            pre_r   <= pre_nxt;
            ctrl_r  <= ctrl_nxt;
            cnt_r   <= cnt_nxt;
            dir_r   <= dir_nxt;
            cap_r   <= cap_nxt;
            flags_r <= flags_nxt;
        end
    end

    for (genvar i = 0; i < 2; i++)
    begin : ch
        logic [15:0] ocr_r;
        logic [15:0] ocr_nxt;
        logic [15:0] buf_r;
        logic [15:0] buf_nxt;
        logic [1:0]  com;
        logic        hit;
        logic        cmp_wr;
        logic        may_tgl;
        logic        oc_r;
        logic        oc_nxt;
        logic        pin_r;
        logic        oe_r;

        assign com     = (i == 0) ? ctrl_r.com_a : ctrl_r.com_b;
        assign hit     = tick & (cnt_r == ocr_r);
        assign may_tgl = (i == 0) & tgl_mode;
        assign cmp_wr  = wr_en
                         && awaddr_r == ((i == 0) ? `OFF_CMPA : `OFF_CMPB);

        always_comb
        begin
            buf_nxt = buf_r;
            ocr_nxt = ocr_r;
            if (upd)
                ocr_nxt = buf_r;
            if (cmp_wr)
            begin
                buf_nxt = merge16(buf_r, wdata_r, wstrb_r) & md.fixed;
                if (!md.fast && !md.dual)
                    ocr_nxt = buf_nxt;
            end
            oc_nxt = oc_r;
            if (md.fast)
            begin
                case (com)
                    // wrap wins so compare equal to top stays constant
                    `COM_TOGGLE: oc_nxt = (may_tgl & hit) ^ oc_r;
                    `COM_2:      oc_nxt = (tick & wrap) ? 1'b0 :
                                          (hit | oc_r);
                    `COM_3:      oc_nxt = (tick & wrap) ? 1'b1 :
                                          (!hit & oc_r);
                    default:     oc_nxt = oc_r;
                endcase
            end
            else if (md.dual)
            begin
                // a match at bottom counts as rising, at top as falling
                case (com)
                    `COM_TOGGLE: oc_nxt = (may_tgl & hit) ^ oc_r;
                    `COM_2:      oc_nxt = hit ? !up_eff : oc_r;
                    `COM_3:      oc_nxt = hit ? up_eff : oc_r;
                    default:     oc_nxt = oc_r;
                endcase
            end
            else if (hit)
            begin
                case (com)
                    `COM_TOGGLE: oc_nxt = !oc_r;
                    `COM_2:      oc_nxt = 1'b0;
                    `COM_3:      oc_nxt = 1'b1;
                    default:     oc_nxt = oc_r;
                endcase
            end
        end

        always_ff @(posedge clk)
        begin
            if (srst)
            begin
                ocr_r <= `CMP_RST;
                buf_r <= `CMP_RST;
                oc_r  <= 1'b0;
                pin_r <= 1'b0;
                oe_r  <= 1'b0;
            end
            else
            begin
                ocr_r <= ocr_nxt;
                buf_r <= buf_nxt;
                oc_r  <= oc_nxt;
                pin_r <= ctrl_r.pin_dir[i] & oc_nxt;
                oe_r  <= ctrl_r.pin_dir[i];
            end
        end
    end

    assign waveform_output_a    = ch[0].pin_r;
    assign waveform_output_a_oe = ch[0].oe_r;
    assign waveform_output_b    = ch[1].pin_r;
    assign waveform_output_b_oe = ch[1].oe_r;

    always_comb
    begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `OFF_CTRL:   rd_val = {19'h0, ctrl_r};
            `OFF_COUNT:  rd_val = {16'h0, cnt_r};
            `OFF_CMPA:   rd_val = {16'h0, ch[0].buf_r};
            `OFF_CMPB:   rd_val = {16'h0, ch[1].buf_r};
            `OFF_CAPTOP: rd_val = {16'h0, cap_r};
            `OFF_FLAGS:  rd_val = {28'h0, flags_r};
            default:
            begin
                rd_val = 32'h0;
                rd_hit = 1'b0;
            end
        endcase
        wr_hit = awaddr_r == `OFF_CTRL || awaddr_r == `OFF_COUNT
                 || awaddr_r == `OFF_CMPA || awaddr_r == `OFF_CMPB
                 || awaddr_r == `OFF_CAPTOP || awaddr_r == `OFF_FLAGS;
    end

    // one write and one read in flight; ready drops until answered
    always_comb
    begin
        awready_nxt = awready_r;
        wready_nxt  = wready_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        arready_nxt = arready_r;
        rvalid_nxt  = rvalid_r;
        rresp_nxt   = rresp_r;
        rdata_nxt   = rdata_r;
        aw_h_nxt    = aw_h_r;
        w_h_nxt     = w_h_r;
        awaddr_nxt  = awaddr_r;
        wdata_nxt   = wdata_r;
        wstrb_nxt   = wstrb_r;
        if (s_axi_awvalid && awready_r)
        begin
            aw_h_nxt    = 1'b1;
            awaddr_nxt  = s_axi_awaddr;
            awready_nxt = 1'b0;
        end
        if (s_axi_wvalid && wready_r)
        begin
            w_h_nxt    = 1'b1;
            wdata_nxt  = s_axi_wdata;
            wstrb_nxt  = s_axi_wstrb;
            wready_nxt = 1'b0;
        end
        if (wr_en)
        begin
            aw_h_nxt   = 1'b0;
            w_h_nxt    = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt  = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (bvalid_r && s_axi_bready)
        begin
            bvalid_nxt  = 1'b0;
            awready_nxt = 1'b1;
            wready_nxt  = 1'b1;
        end
        if (s_axi_arvalid && arready_r)
        begin
            arready_nxt = 1'b0;
            rvalid_nxt  = 1'b1;
            rdata_nxt   = rd_val;
            rresp_nxt   = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (rvalid_r && s_axi_rready)
        begin
            rvalid_nxt  = 1'b0;
            arready_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            awready_r <= `RDY_RST;
            wready_r  <= `RDY_RST;
            bvalid_r  <= 1'b0;
            bresp_r   <= `RESP_OKAY;
            arready_r <= `RDY_RST;
            rvalid_r  <= 1'b0;
            rresp_r   <= `RESP_OKAY;
            rdata_r   <= 32'h0;
            aw_h_r    <= 1'b0;
            w_h_r     <= 1'b0;
            awaddr_r  <= 8'h0;
            wdata_r   <= 32'h0;
            wstrb_r   <= 4'h0;
        end
        else
        begin
            awready_r <= awready_nxt;
            wready_r  <= wready_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r  <= rvalid_nxt;
            rresp_r   <= rresp_nxt;
            rdata_r   <= rdata_nxt;
            aw_h_r    <= aw_h_nxt;
            w_h_r     <= w_h_nxt;
            awaddr_r  <= awaddr_nxt;
            wdata_r   <= wdata_nxt;
            wstrb_r   <= wstrb_nxt;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_top_up;
        tick && md.dual && !wr_en && at_top
        && dir_r == timer16_pkg::DIR_UP;
    endsequence

    sequence s_turned;
        dir_r == timer16_pkg::DIR_DOWN
        && cnt_r == $past(cnt_r) - 16'h0001;
    endsequence

    ovf_wrap_a: assert property (
        tick && md.fast && at_top && !wr_en
        |=> flags_r[`FLG_OVF] && cnt_r == `CNT_BOTTOM)
        else $error("fast wrap missed overflow or clear");

    count_hold_a: assert property (
        !tick && !wr_en |=> $stable(cnt_r))
        else $error("counter moved without tick");

    pc_turn_a: assert property (s_top_up |=> s_turned)
        else $error("dual slope did not reverse at top");

    pc_bottom_a: assert property (
        tick && md.dual && bottom_dn && !wr_en
        |=> flags_r[`FLG_OVF] && dir_r == timer16_pkg::DIR_UP)
        else $error("bottom turn missed overflow");

    buf_load_a: assert property (
        tick && md.fast && at_top && !wr_en
        |=> ch[0].ocr_r == $past(ch[0].buf_r))
        else $error("compare buffer not loaded at top");

    match_flag_a: assert property (
        ch[0].hit |=> flags_r[`FLG_MA])
        else $error("compare match flag not set");

    pin_gate_a: assert property (
        !ctrl_r.pin_dir[0]
        |=> !waveform_output_a && !waveform_output_a_oe)
        else $error("pin driven while direction is input");

    mask_write_a: assert property (
        wr_en && awaddr_r == `OFF_CMPA && md.fixed != `CNT_MAX
        |=> (ch[0].buf_r & ~$past(md.fixed)) == 16'h0)
        else $error("upper compare bits not masked");

    fast_set_a: assert property (
        tick && md.fast && wrap && ctrl_r.com_a == `COM_3 && !wr_en
        |=> ch[0].oc_r)
        else $error("non-inverted output not set at wrap");

endmodule

// file: test/pwm_load.sv
`timescale 1ns/100ps
// load on one pwm pin: pulled down while released, counts high cycles
module pwm_load
(
    input  logic        clk,
    input  logic        pin,
    input  logic        oe,
    input  logic        clr,
    output logic [31:0] high_cnt,
    output logic        leak
);
    logic pad;
    // a released pin sits at the pull-down, never at the waveform
    assign pad = oe ? pin : 1'b0;
    initial high_cnt = 32'h0;
    initial leak = 1'b0;
    always @(posedge clk)
    begin
        high_cnt <= clr ? 32'h0 : high_cnt + {31'h0, pad};
        if (!oe && pin)
            leak <= 1'b1;
    end
endmodule

// file: test/timer16_pwm_tb.sv
`timescale 1ns/100ps
`include "timer16_defs.svh"
module timer16_pwm_tb;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        clr = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, rsp;
    logic [31:0] rdata, hi_a, hi_b, q;
    logic        pin_a, oe_a, pin_b, oe_b, leak_a, leak_b;
    int          miscompares = 0;
    int          samples_checked = 0;
    int          seed = 32'h6e14b48c;
    // mode, selector a, clock select, compare a, capture top
    // variable tops at least three, never below compare
    logic [31:0] cases [19] = '{32'h53_1_040_00, 32'h52_1_040_00,
        32'h53_1_000_00, 32'h53_1_0ff_00, 32'h52_1_0ff_00, 32'hf1_5_003_00,
        32'he3_3_003_0f, 32'h12_1_040_00, 32'h13_1_040_00, 32'h12_1_000_00,
        32'h12_1_0ff_00, 32'hb1_4_003_00, 32'ha2_1_005_0f, 32'h63_1_1f0_00,
        32'h72_1_300_00, 32'h22_1_100_00, 32'h33_1_200_00, 32'h53_2_fff_00,
        32'h12_1_fff_00};

    timer16_pwm timer16_pwm_i
    (
        .clk(clk), .srst(srst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .waveform_output_a(pin_a),
        .waveform_output_a_oe(oe_a), .waveform_output_b(pin_b),
        .waveform_output_b_oe(oe_b)
    );
    pwm_load pwm_load_a_i (.clk(clk), .pin(pin_a), .oe(oe_a), .clr(clr),
        .high_cnt(hi_a), .leak(leak_a));
    pwm_load pwm_load_b_i (.clk(clk), .pin(pin_b), .oe(oe_b), .clr(clr),
        .high_cnt(hi_b), .leak(leak_b));

    initial forever #25 clk = ~clk;

    task automatic print_verdict;
        if (miscompares == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            n++;
        end while (!bvalid && n < 64);
        bready <= 1'b0;
        rsp = bresp;
        chk({31'h0, n < 64}, 32'h1);
    endtask

    task automatic axr(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'b0;
            n++;
        end while (!rvalid && n < 64);
        rready <= 1'b0;
        q = rdata;
        rsp = rresp;
        chk({31'h0, n < 64}, 32'h1);
    endtask

    // high cycles over two whole periods, so the phase does not matter
    function automatic int want(int dual, int per, int cmp, int sel);
        if (sel == 1)
            return per;
        if (dual != 0)
            return 2 * ((sel == 2) ? 2 * cmp : per - 2 * cmp);
        return 2 * ((sel == 3) ? cmp + 1 : per - cmp - 1);
    endfunction

    task automatic run(input logic [31:0] v);
        logic [3:0] m;
        int         cmp, top, per, dv, dual, exp_b;
        m = v[31:28];
        cmp = (v[19:8] == 12'hfff) ? ($random(seed) & 32'hff) : v[19:8];
        dual = (m < 4'h4 || m == 4'ha || m == 4'hb);
        top = (m == 4'he || m == 4'ha) ? v[7:0] :
              m[3] ? cmp : (128 << m[1:0]) - 1;
        per = (dual != 0) ? 2 * top : top + 1;
        case (v[22:20])
            3'h2:    dv = 8;
            3'h3:    dv = 64;
            3'h4:    dv = 256;
            3'h5:    dv = 1024;
            default: dv = 1;
        endcase
        // normal mode while stopped: compare lands directly, count restarts
        axw(`OFF_CTRL, 32'h0);
        axw(`OFF_COUNT, 32'h0);
        axw(`OFF_CMPA, cmp);
        axw(`OFF_CMPB, cmp);
        axw(`OFF_CAPTOP, {24'h0, v[7:0]});
        // channel b: selector two on the same compare, pin on for odd a
        axw(`OFF_CTRL, {19'h0, v[24], 1'b1, v[22:20], 2'b10, v[25:24], m});
        repeat (2 * per * dv) @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (2 * per * dv) @(posedge clk);
        #1;
        chk(hi_a, 32'(want(dual, per, cmp, int'(v[27:24])) * dv));
        chk({31'h0, oe_a}, 32'h1);
        exp_b = (v[24] != 1'b0) ? want(dual, per, cmp, 2) * dv : 0;
        chk(hi_b, 32'(exp_b));
        chk({31'h0, oe_b}, {31'h0, v[24]});
    endtask

    initial
    begin
        #4600000;
        miscompares++;
        print_verdict;
    end

    initial
    begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        axr(`OFF_CTRL);
        chk(q, 32'h0);
        axr(8'h18);
        chk({30'h0, rsp}, {30'h0, `RESP_SLVERR});
        axw(8'h18, 32'h1);
        chk({30'h0, rsp}, {30'h0, `RESP_SLVERR});
        axw(`OFF_CTRL, 32'h5);
        axw(`OFF_CMPA, 32'h1234);
        axr(`OFF_CMPA);
        chk(q, 32'h34);
        foreach (cases[i])
            run(cases[i]);
        axr(`OFF_FLAGS);
        chk(q, 32'hf);
        axw(`OFF_CTRL, 32'h0);
        axw(`OFF_FLAGS, 32'hf);
        axr(`OFF_FLAGS);
        chk(q, 32'h0);
        chk({hi_b[30:0], leak_b | leak_a}, 32'h0);
        print_verdict;
    end
endmodule
